// ---- hw/gpio_regs.svh ----
// Register offsets, reset values and field positions of the port block.
// Assumes byte addresses on an 8-bit register address, one word per register.
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// Port width in pins
`define PORT_WIDTH          16
`define ADDR_WIDTH          8
`define DATA_WIDTH          32

// Base register offsets; aliases sit at base + 0x4, 0x8, 0xc
`define OFS_PIN_DIRECTION   8'h00
`define OFS_OUTPUT_LATCH    8'h10
`define OFS_PIN_LEVEL       8'h20
`define OFS_OPEN_DRAIN      8'h30
`define OFS_ANALOG_SELECT   8'h40
`define OFS_CHANGE_IRQ_EN   8'h50
`define OFS_CHANGE_FLAG     8'h60
`define OFS_WEAK_PULLUP     8'h70
`define OFS_WEAK_PULLDOWN   8'h80
`define OFS_CHANGE_CONTROL  8'h90

// Alias offsets within one register group
`define OFS_ALIAS_CLR       2'h1
`define OFS_ALIAS_SET       2'h2
`define OFS_ALIAS_INV       2'h3

// Reset values
`define RST_PIN_DIRECTION   16'hffff
`define RST_OUTPUT_LATCH    16'h0000
`define RST_OPEN_DRAIN      16'h0000
`define RST_ANALOG_SELECT   16'hffff
`define RST_CHANGE_IRQ_EN   16'h0000
`define RST_WEAK_PULL       16'h0000
`define RST_CHANGE_CONTROL  16'h0000

// Change notice control: module on bit
`define CTRL_ON_BIT         15

`endif

// ---- hw/gpio_pkg.sv ----
// Types shared by the port block files.
// Assumes gpio_regs.svh supplies the numbers.
package gpio_pkg;

   // Operation applied by a register write
   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_CLR   = 2'h1,
      OP_SET   = 2'h2,
      OP_INV   = 2'h3
   } alias_op_t;

endpackage : gpio_pkg

// ---- hw/bit_sync.sv ----
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit is unrelated to its neighbours.
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,       // Block clock
   input  wire logic             rst,       // Synchronous reset
   input  wire logic [WIDTH-1:0] async_in,  // Levels from outside
   output logic      [WIDTH-1:0] sync_out   // Levels on clk
);

   logic [WIDTH-1:0] meta_reg;

   // Two flip-flops; the first is read only by the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : bit_sync

// ---- hw/alias_reg.sv ----
// One port register with write, clear, set and invert access.
// Assumes the caller decodes the operation from the address.
`timescale 1ns/1ps
module alias_reg
   import gpio_pkg::*;
#(
   parameter int               WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET = '0
) (
   input  wire logic             clk,    // Block clock
   input  wire logic             rst,    // Synchronous reset
   input  wire logic             wr_en,  // Write to this group
   input  alias_op_t             op,     // Operation of the write
   input  wire logic [WIDTH-1:0] wdata,  // Write data
   output logic      [WIDTH-1:0] q_reg   // Stored value
);

   logic [WIDTH-1:0] q_next;

   always_comb begin
      q_next = q_reg;
      if (wr_en) begin
         case (op)
            OP_WRITE: q_next = wdata;
            OP_CLR:   q_next = q_reg & ~wdata;
            OP_SET:   q_next = q_reg | wdata;
            OP_INV:   q_next = q_reg ^ wdata;
            default:  q_next = q_reg;
         endcase
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (rst) begin
         q_reg <= RESET;
      end else begin
         q_reg <= q_next;
      end
   end

endmodule : alias_reg

// ---- hw/gpio_port_with_change_notice.sv ----
// Digital I/O port with change notice, pulls and atomic alias registers.
// Assumes a plain register port on clk and pins from outside the clock domain.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "gpio_regs.svh"
module gpio_port_with_change_notice
   import gpio_pkg::*;
(
   input  wire logic                   clk,            // 20 MHz block clock
   input  wire logic                   rst,            // Synchronous reset, high
   input  wire logic [`ADDR_WIDTH-1:0] addr,           // Register byte address
   input  wire logic [`DATA_WIDTH-1:0] wdata,          // Write data
   input  wire logic                   wr,             // Write strobe
   input  wire logic                   rd,             // Read strobe
   output logic      [`DATA_WIDTH-1:0] rdata,          // Read data, cycle after rd
   input  wire logic [`PORT_WIDTH-1:0] pin_in,         // Pad input levels
   output logic      [`PORT_WIDTH-1:0] pin_out,        // Pad output levels
   output logic      [`PORT_WIDTH-1:0] pin_oe,         // Pad drive enables
   output logic      [`PORT_WIDTH-1:0] analog_mode,    // Pad analog switch
   output logic      [`PORT_WIDTH-1:0] pullup_en,      // Weak pull-up enables
   output logic      [`PORT_WIDTH-1:0] pulldown_en,    // Weak pull-down enables
   output logic                        change_irq      // Change request, wakes core
);

   localparam int W = `PORT_WIDTH;

   // ************************************************************
   // Address decode
   // ************************************************************

   logic [7:0]   group;   // Register group, as wide as the offsets
   alias_op_t    op;
   logic [W-1:0] wd;
   logic         we_dir;  // Direction write
   logic         we_lat;  // Latch write, also from level address
   logic         we_odc;  // Open drain write
   logic         we_ans;  // Analog select write
   logic         we_cen;  // Change enable write
   logic         we_flg;  // Change flag write
   logic         we_pu;   // Pull-up write
   logic         we_pd;   // Pull-down write
   logic         we_ctl;  // Change control write

   // Group from upper nibble, operation from word within group
   // alias placement
   // Upper nibble kept eight bits wide so offset compares match in width
   assign group = {4'h0, addr[7:4]};
   assign op    = alias_op_t'(addr[3:2]);
   assign wd    = wdata[W-1:0];

   // Per-register write enables
   always_comb begin
      we_dir = 1'b0;
      we_lat = 1'b0;
      we_odc = 1'b0;
      we_ans = 1'b0;
      we_cen = 1'b0;
      we_flg = 1'b0;
      we_pu  = 1'b0;
      we_pd  = 1'b0;
      we_ctl = 1'b0;
      // Unaligned writes are dropped
      if (!wr || addr[1:0] != 2'h0) begin
         we_dir = 1'b0;
      end else if (group == `OFS_PIN_DIRECTION >> 4) begin
         we_dir = 1'b1;
      end else if (group == `OFS_OUTPUT_LATCH >> 4) begin
         we_lat = 1'b1;
      end else if (group == `OFS_PIN_LEVEL >> 4) begin
         we_lat = 1'b1;
      end else if (group == `OFS_OPEN_DRAIN >> 4) begin
         we_odc = 1'b1;
      end else if (group == `OFS_ANALOG_SELECT >> 4) begin
         we_ans = 1'b1;
      end else if (group == `OFS_CHANGE_IRQ_EN >> 4) begin
         we_cen = 1'b1;
      end else if (group == `OFS_CHANGE_FLAG >> 4) begin
         we_flg = 1'b1;
      end else if (group == `OFS_WEAK_PULLUP >> 4) begin
         we_pu = 1'b1;
      end else if (group == `OFS_WEAK_PULLDOWN >> 4) begin
         we_pd = 1'b1;
      end else if (group == `OFS_CHANGE_CONTROL >> 4) begin
         we_ctl = 1'b1;
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************

   logic [W-1:0] dir_q;  // Direction, one is input
   logic [W-1:0] lat_q;  // Output latch
   logic [W-1:0] odc_q;  // Open drain select
   logic [W-1:0] ans_q;  // Analog select
   logic [W-1:0] cen_q;  // Change enables
   logic [W-1:0] pu_q;   // Pull-up enables
   logic [W-1:0] pd_q;   // Pull-down enables
   logic [W-1:0] ctl_q;  // Change control

   alias_reg #(.WIDTH(W), .RESET(`RST_PIN_DIRECTION)) u_dir (
      .clk(clk), .rst(rst), .wr_en(we_dir), .op(op), .wdata(wd), .q_reg(dir_q));

   alias_reg #(.WIDTH(W), .RESET(`RST_OUTPUT_LATCH)) u_lat (
      .clk(clk), .rst(rst), .wr_en(we_lat), .op(op), .wdata(wd), .q_reg(lat_q));

   alias_reg #(.WIDTH(W), .RESET(`RST_OPEN_DRAIN)) u_odc (
      .clk(clk), .rst(rst), .wr_en(we_odc), .op(op), .wdata(wd), .q_reg(odc_q));

   alias_reg #(.WIDTH(W), .RESET(`RST_ANALOG_SELECT)) u_ans (
      .clk(clk), .rst(rst), .wr_en(we_ans), .op(op), .wdata(wd), .q_reg(ans_q));

   alias_reg #(.WIDTH(W), .RESET(`RST_CHANGE_IRQ_EN)) u_cen (
      .clk(clk), .rst(rst), .wr_en(we_cen), .op(op), .wdata(wd), .q_reg(cen_q));

   alias_reg #(.WIDTH(W), .RESET(`RST_WEAK_PULL)) u_pu (
      .clk(clk), .rst(rst), .wr_en(we_pu), .op(op), .wdata(wd), .q_reg(pu_q));

   alias_reg #(.WIDTH(W), .RESET(`RST_WEAK_PULL)) u_pd (
      .clk(clk), .rst(rst), .wr_en(we_pd), .op(op), .wdata(wd), .q_reg(pd_q));

   // Change notice on bit lives here
   alias_reg #(.WIDTH(W), .RESET(`RST_CHANGE_CONTROL)) u_ctl (
      .clk(clk), .rst(rst), .wr_en(we_ctl), .op(op), .wdata(wd), .q_reg(ctl_q));

   // ************************************************************
   // Pin sampling and change notice
   // ************************************************************

   logic [W-1:0] pin_sync;
   logic [W-1:0] ref_reg;
   logic [W-1:0] flag_reg, flag_next;
   logic [W-1:0] level_view;
   logic [W-1:0] change_evt;
   logic         level_rd;
   logic         cn_on;

   // Pads are asynchronous; two flops before any use
   bit_sync #(.WIDTH(W)) u_sync (
      .clk(clk), .rst(rst), .async_in(pin_in), .sync_out(pin_sync));

   assign level_view = pin_sync & ~(ans_q & dir_q);
   assign level_rd   = rd && addr == `OFS_PIN_LEVEL;
   assign cn_on      = ctl_q[`CTRL_ON_BIT];

   // runs regardless of sleep state
   // A level read captures pin_sync, which it returns with analog inputs masked, so that cycle
   // reports no change; later changes compare against the new capture
   assign change_evt = (cn_on && !level_rd) ? (cen_q & (pin_sync ^ ref_reg)) : '0;

   always_ff @(posedge clk) begin
      if (rst) begin
         ref_reg <= '0;
      end else if (level_rd) begin
         ref_reg <= pin_sync;
      end
   end

   // flag since last read; hardware set wins over clear
   // Software may also write or alias the flags
   always_comb begin
      flag_next = flag_reg;
      if (we_flg) begin
         case (op)
            OP_WRITE: flag_next = wd;
            OP_CLR:   flag_next = flag_reg & ~wd;
            OP_SET:   flag_next = flag_reg | wd;
            OP_INV:   flag_next = flag_reg ^ wd;
            default:  flag_next = flag_reg;
         endcase
      end
      if (level_rd) begin
         flag_next = '0;
      end
      flag_next = flag_next | change_evt;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         change_irq <= 1'b0;
      end else begin
         change_irq <= cn_on && |(flag_next & cen_q);
      end
   end

   // ************************************************************
   // Pad drive
   // ************************************************************

   // Open drain releases the pad rather than driving high
   // outputs drive latch
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out     <= '0;
         pin_oe      <= '0;
         analog_mode <= `RST_ANALOG_SELECT;
         pullup_en   <= '0;
         pulldown_en <= '0;
      end else begin
         pin_out     <= lat_q & ~odc_q;
         pin_oe      <= ~dir_q & ~(odc_q & lat_q);
         analog_mode <= ans_q;
         pullup_en   <= pu_q;
         pulldown_en <= pd_q;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************

   logic [W-1:0] rd_word;

   // latch reads the latch, not pins
   always_comb begin
      rd_word = '0;
      if (addr[3:0] != 4'h0) begin
         rd_word = '0;
      end else if (group == `OFS_PIN_DIRECTION >> 4) begin
         rd_word = dir_q;
      end else if (group == `OFS_OUTPUT_LATCH >> 4) begin
         rd_word = lat_q;
      end else if (group == `OFS_PIN_LEVEL >> 4) begin
         rd_word = level_view;
      end else if (group == `OFS_OPEN_DRAIN >> 4) begin
         rd_word = odc_q;
      end else if (group == `OFS_ANALOG_SELECT >> 4) begin
         rd_word = ans_q;
      end else if (group == `OFS_CHANGE_IRQ_EN >> 4) begin
         rd_word = cen_q;
      end else if (group == `OFS_CHANGE_FLAG >> 4) begin
         rd_word = flag_reg;
      end else if (group == `OFS_WEAK_PULLUP >> 4) begin
         rd_word = pu_q;
      end else if (group == `OFS_WEAK_PULLDOWN >> 4) begin
         rd_word = pd_q;
      end else if (group == `OFS_CHANGE_CONTROL >> 4) begin
         rd_word = ctl_q;
      end
   end

   // Upper half of the word always reads zero
   // Read data stands one cycle, zero otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         rdata <= {{(`DATA_WIDTH-W){1'b0}}, rd_word};
      end else begin
         rdata <= '0;
      end
   end

endmodule : gpio_port_with_change_notice

// ---- tb/gpio_port_properties.sv ----
// Port-level checks of the port block.
// Assumes one clock and a synchronous high reset.
`timescale 1ns/1ps
module gpio_port_properties (
   input wire logic        clk,         // Block clock
   input wire logic        rst,         // Synchronous reset
   input wire logic [7:0]  addr,        // Register address
   input wire logic [31:0] wdata,       // Write data
   input wire logic        wr,          // Write strobe
   input wire logic        rd,          // Read strobe
   input wire logic [31:0] rdata,       // Read data
   input wire logic [15:0] pin_in,      // Pad levels
   input wire logic [15:0] pin_out,     // Pad outputs
   input wire logic [15:0] pin_oe,      // Pad enables
   input wire logic [15:0] analog_mode, // Analog switch
   input wire logic [15:0] pullup_en,   // Pull-ups
   input wire logic [15:0] pulldown_en, // Pull-downs
   input wire logic        change_irq   // Change request
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_reset_state: assert property ($past(rst) |-> pin_oe == 16'h0 && analog_mode == 16'hffff)
      else $error("pads wrong after reset");
   a_dir_input: assert property (wr && addr == 8'h00 ##1 !(wr && addr[7:4] == 4'h0)
      |=> (pin_oe & $past(wdata[15:0], 2)) == 16'h0) else $error("input pin driven");
   a_od_low: assert property (wr && addr == 8'h30 ##1 !(wr && addr[7:4] == 4'h3)
      |=> (pin_out & $past(wdata[15:0], 2)) == 16'h0) else $error("open drain drove high");
   a_analog_copy: assert property (wr && addr == 8'h40 ##1 !(wr && addr[7:4] == 4'h4)
      |=> analog_mode == $past(wdata[15:0], 2)) else $error("analog mode stale");
   a_pull_set: assert property (wr && addr == 8'h78 ##1 !(wr && addr[7:4] == 4'h7)
      |=> (pullup_en & $past(wdata[15:0], 2)) == $past(wdata[15:0], 2)) else $error("set lost");
   a_pull_clear: assert property (wr && addr == 8'h84 ##1 !(wr && addr[7:4] == 4'h8)
      |=> (pulldown_en & $past(wdata[15:0], 2)) == 16'h0) else $error("clear lost");
   a_alias_rd_zero: assert property (rd && addr[3:0] != 4'h0 |=> rdata == 32'h0)
      else $error("alias read not zero");
   a_idle_zero: assert property (!rd |=> rdata == 32'h0)
      else $error("read data without read");
   a_irq_clear: assert property (rd && addr == 8'h20 |=> !change_irq)
      else $error("request stayed after level read");
endmodule : gpio_port_properties

// ---- tb/pad_model.sv ----
// Pads and the outside devices that sit on them.
// Assumes the block clock paces the floating-pad pattern.
`timescale 1ns/1ps
module pad_model (
   input wire logic        clk,         // Pattern clock
   input wire logic [15:0] pin_out,     // Block levels
   input wire logic [15:0] pin_oe,      // Block enables
   input wire logic [15:0] pullup_en,   // Pull-ups
   input wire logic [15:0] pulldown_en, // Pull-downs
   input wire logic [15:0] ext_val,     // Device levels
   input wire logic [15:0] ext_en,      // Device drives
   output logic     [15:0] pin_in       // Pad levels
);
   logic [15:0] flt = 16'h5a5a;
   // Undriven pads change every cycle
   always @(posedge clk) flt <= ~flt;
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pullup_en[i]) pin_in[i] = 1'b1;
         else if (pulldown_en[i]) pin_in[i] = 1'b0;
         else pin_in[i] = flt[i];
      end
   end
endmodule : pad_model

// ---- tb/testbench.sv ----
// Self-checking bench of the port block with a pad model.
// Assumes the register header and package are compiled first.
`timescale 1ns/1ps
`include "gpio_regs.svh"
module testbench;
   import gpio_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [15:0] pin_in, pin_out, pin_oe, analog_mode, pullup_en, pulldown_en;
   logic        change_irq;
   logic [15:0] ext_val = 16'h0, ext_en = 16'h0, v, m;
   logic [7:0]  regs [3] = '{8'h50, 8'h70, 8'h80};
   int          fails = 0, check_count = 0, k;
   always #25 clk = ~clk;
   gpio_port_with_change_notice u_gpio_port_with_change_notice (.clk(clk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .analog_mode(analog_mode), .pullup_en(pullup_en),
      .pulldown_en(pulldown_en), .change_irq(change_irq));
   pad_model u_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pullup_en), .pulldown_en(pulldown_en), .ext_val(ext_val),
      .ext_en(ext_en), .pin_in(pin_in));
   function automatic logic [15:0] alias_f(input alias_op_t op, input logic [15:0] b, c);
      return op == OP_CLR ? b & ~c : (op == OP_SET ? b | c : b ^ c);
   endfunction : alias_f
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= {16'h0, d};
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : put
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata[15:0], e);
   endtask : rchk
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask : settle
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h7ad1a6b9));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rchk(`OFS_PIN_DIRECTION, 16'hffff);
      rchk(`OFS_ANALOG_SELECT, 16'hffff);
      check(pin_oe, 16'h0);
      $display("test reset done");
      put(`OFS_ANALOG_SELECT, 16'h0);
      put(`OFS_PIN_DIRECTION, 16'h0);
      for (int i = 0; i < 3; i++) begin
         v = 16'($urandom);
         put(i == 1 ? `OFS_PIN_LEVEL : `OFS_OUTPUT_LATCH, v);
         settle(4);
         check(pin_oe, 16'hffff);
         check(pin_out, v);
         rchk(`OFS_OUTPUT_LATCH, v);
         rchk(`OFS_PIN_LEVEL, v);
      end
      m = 16'($urandom);
      put(`OFS_OPEN_DRAIN, m);
      settle(2);
      check(pin_out, v & ~m);
      check(pin_oe, ~(v & m));
      put(`OFS_OPEN_DRAIN + 8'h4, m);
      rchk(`OFS_OPEN_DRAIN, 16'h0);
      put(`OFS_ANALOG_SELECT, 16'hffff);
      settle(2);
      check(pin_oe, 16'hffff);
      check(analog_mode, 16'hffff);
      $display("test outputs done");
      v = 16'($urandom);
      ext_val <= v;
      ext_en <= 16'hffff;
      put(`OFS_PIN_DIRECTION, 16'hffff);
      put(`OFS_ANALOG_SELECT, m);
      settle(4);
      rchk(`OFS_PIN_LEVEL, v & ~m);
      rchk(8'ha0, 16'h0);
      foreach (regs[j]) for (int o = 1; o < 4; o++) begin
         v = 16'($urandom);
         m = 16'($urandom);
         put(regs[j], v);
         put(regs[j] + 8'(4 * o), m);
         rchk(regs[j], alias_f(alias_op_t'(o), v, m));
         rchk(regs[j] + 8'(4 * o), 16'h0);
      end
      m = 16'($urandom);
      put(`OFS_WEAK_PULLUP, m);
      put(`OFS_WEAK_PULLDOWN, ~m);
      settle(2);
      check(pullup_en, m);
      check(pulldown_en, ~m);
      $display("test aliases done");
      k = $urandom_range(15);
      m = 16'h1 << k;
      v = ext_val;
      put(`OFS_ANALOG_SELECT, 16'h0);
      put(`OFS_CHANGE_CONTROL, 16'h8000);
      put(`OFS_CHANGE_IRQ_EN, m);
      settle(4);
      rchk(`OFS_PIN_LEVEL, v);
      ext_val <= v ^ {m[14:0], m[15]};
      settle(6);
      check({15'h0, change_irq}, 16'h0);
      rchk(`OFS_CHANGE_FLAG, 16'h0);
      ext_val <= v ^ m ^ {m[14:0], m[15]};
      for (int i = 0; i < 8 && change_irq !== 1'b1; i++) @(negedge clk);
      check({15'h0, change_irq}, 16'h1);
      rchk(`OFS_CHANGE_FLAG, m);
      rchk(`OFS_PIN_LEVEL, v ^ m ^ {m[14:0], m[15]});
      check({15'h0, change_irq}, 16'h0);
      rchk(`OFS_CHANGE_FLAG, 16'h0);
      $display("test change notice done");
      tally_and_finish();
   end
endmodule : testbench
bind gpio_port_with_change_notice gpio_port_properties u_props (.clk(clk), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .analog_mode(analog_mode), .pullup_en(pullup_en),
   .pulldown_en(pulldown_en), .change_irq(change_irq));
